// ==== hw/csd_pkg.sv ====
//////////////////////////////////////////////////////////////////////
// Purpose: shared constants for clock select and distribution
// Assumes: 32-bit axi4-lite register bus, byte addresses
// Notes: all offsets and field positions live here
//////////////////////////////////////////////////////////////////////
package csd_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CLK_CTRL = 8'h00;
  localparam logic [7:0] OFS_PERIPH_SEL = 8'h04;
  localparam logic [7:0] OFS_SYS_CONFIG_TWO = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  // clock control fields
  localparam int MDIV_LSB = 0;
  localparam int MSRC_LSB = 4;
  localparam int ASRC_BIT = 8;
  localparam int SDIV_LSB = 12;
  localparam int FREF_BIT = 16;
  localparam logic [31:0] CTRL_MASK = 32'h0001_3137;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // peripheral select: two bits per peripheral at 2*index
  localparam logic [31:0] PSEL_MASK = 32'h0000_3fff;
  localparam logic [31:0] PSEL_RST = 32'h0000_0000;
  // system config two: counter gate bit
  localparam int CTR_GATE_BIT = 0;
  localparam logic [31:0] CFG2_MASK = 32'h0000_0001;
  localparam logic [31:0] CFG2_RST = 32'h0000_0000;
  // status bits
  localparam int STAT_FAULT = 0;
  localparam int STAT_LIVE = 1;
  // peripheral indices
  localparam int P_TIMER_ZERO = 0;
  localparam int P_TIMER_ONE = 1;
  localparam int P_SERIAL_A = 2;
  localparam int P_SERIAL_B = 3;
  localparam int P_WATCHDOG = 4;
  localparam int P_CONVERTER = 5;
  localparam int P_COUNTER = 6;
  localparam int NUM_PERIPH = 7;
  // select codes
  localparam logic [1:0] SEL_PIN = 2'h0;
  localparam logic [1:0] SEL_AUX = 2'h1;
  localparam logic [1:0] SEL_SUB = 2'h2;
  localparam logic [1:0] SEL_ALT = 2'h3;
  localparam logic [1:0] WDT_VLO = 2'h2;
  localparam logic [1:0] ADC_MOD = 2'h0;
  localparam logic [1:0] RTC_SUB = 2'h1;
  localparam logic [1:0] RTC_XTAL = 2'h2;
  // main source codes; the modulation clock has none
  localparam logic [1:0] MSRC_DCO = 2'h0;
  localparam logic [1:0] MSRC_RC = 2'h1;
  localparam logic [1:0] MSRC_XTAL = 2'h2;
  localparam logic [1:0] MSRC_VLO = 2'h3;
  // synchronised input count
  localparam int NUM_SYNC = 10;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : csd_pkg

// ==== hw/csd_clock_select.sv ====
//////////////////////////////////////////////////////////////////////
// Purpose: clock source selection, prescaling and distribution
// Assumes: oscillators and pins are slow against I_CLK, sampled
// Notes: generated clocks are flop levels in the I_CLK domain
//////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps

// glitch-free source switch with power-of-two divider
module csd_divider #(
  parameter int W = 7,
  parameter int DW = 3
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // sources and settings
  input wire logic [3:0] i_srcs,
  input wire logic [1:0] i_sel,
  input wire logic [DW-1:0] i_div,
  // divided clock
  output logic o_clk
);
  logic [1:0] sel;
  logic [DW-1:0] div;
  logic [W-1:0] cnt;
  logic src;
  logic src_d;
  logic lvl;
  logic sw;

  // selected source and divided level
  assign src = i_srcs[sel];
  assign lvl = (div == '0) ? src : cnt[div - 1'b1];
  // switch only low
  // settings move only while old output, level and source are all low
  assign sw = ((i_sel != sel) || (i_div != div)) && !lvl && !src && !o_clk;

  // edge history of the source
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      src_d <= 1'b0;
    else
      src_d <= src;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      cnt <= '0;
    else if (sw)
      cnt <= '0; // fresh period after a switch
    else if (src && !src_d)
      cnt <= cnt + 1'b1;
  end

  // active settings
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sel <= '0;
      div <= '0;
    end
    else if (sw)
    begin
      sel <= i_sel;
      div <= i_div;
    end
  end

  // registered output
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_clk <= 1'b0;
    else
      o_clk <= lvl;
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence rise_s;
    src && !src_d && !sw;
  endsequence

  switch_low_a: assert property (sw |=> !o_clk)
    else $error("switch taken while output high");
  half_toggle_a: assert property ((div == 1) and rise_s |=> lvl != $past(lvl))
    else $error("divide by two did not toggle");
  rise_cause_a: assert property ($rose(o_clk) |-> $past(src) || $past(src, 2))
    else $error("output rose without source");
endmodule : csd_divider

//////////////////////////////////////////////////////////////////////
module csd_clock_select (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // axi4-lite write address
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [7:0] I_AWADDR,
  // axi4-lite write data
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  // axi4-lite write response
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  // axi4-lite read
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [7:0] I_ARADDR,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  // oscillator sources
  input wire logic I_DIGITALLY_CONTROLLED_OSC,
  input wire logic I_INTERNAL_RC_OSC,
  input wire logic I_CRYSTAL_CLOCK,
  input wire logic I_CRYSTAL_FAULT,
  input wire logic I_VERY_LOW_FREQ_CLOCK,
  input wire logic I_MODULATION_CLOCK,
  // external clock pins
  input wire logic I_TIMER_ZERO_EXT_CLOCK_PIN,
  input wire logic I_TIMER_ONE_EXT_CLOCK_PIN,
  input wire logic I_SERIAL_A_EXT_CLOCK_PIN,
  input wire logic I_SERIAL_B_EXT_CLOCK_PIN,
  // system clocks
  output logic O_MAIN_CLK,
  output logic O_SUB_MAIN_CLK,
  output logic O_AUX_CLK,
  output logic O_FLL_REF_CLK,
  // peripheral clocks
  output logic O_TIMER_ZERO_CLK,
  output logic O_TIMER_ONE_CLK,
  output logic O_SERIAL_A_CLK,
  output logic O_SERIAL_B_CLK,
  output logic O_WATCHDOG_CLK,
  output logic O_CONVERTER_CLK,
  output logic O_COUNTER_CLK
);
  logic [csd_pkg::NUM_SYNC-1:0] raw;
  logic [csd_pkg::NUM_SYNC-1:0] sync_a;
  logic [csd_pkg::NUM_SYNC-1:0] sync_b;
  logic [csd_pkg::NUM_SYNC-1:0] sync_c;
  logic [csd_pkg::NUM_SYNC-1:0] pin_q;
  logic dco_q, rc_q, xt_q, fault_q, vlo_q, mod_q;
  logic [3:0] ext_q;
  logic xt_eff;
  logic aux_any;
  logic [31:0] ctrl, psel, cfg2;
  logic fault_sticky;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic wr_hit;
  logic [31:0] rd_val;
  logic rd_hit;
  logic gate_act;
  logic [3:0] cand [csd_pkg::NUM_PERIPH];
  logic [1:0] sel_act [csd_pkg::NUM_PERIPH];
  logic [csd_pkg::NUM_PERIPH-1:0] pclk;
  logic [csd_pkg::NUM_PERIPH-1:0] swp;

  ////////////////////////////////////////////////////////////////////
  // input synchronisers: change counts once stages two and three agree
  assign raw = {I_SERIAL_B_EXT_CLOCK_PIN, I_SERIAL_A_EXT_CLOCK_PIN,
                I_TIMER_ONE_EXT_CLOCK_PIN, I_TIMER_ZERO_EXT_CLOCK_PIN,
                I_MODULATION_CLOCK, I_VERY_LOW_FREQ_CLOCK, I_CRYSTAL_FAULT,
                I_CRYSTAL_CLOCK, I_INTERNAL_RC_OSC, I_DIGITALLY_CONTROLLED_OSC};
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      sync_a <= '0;
      sync_b <= '0;
      sync_c <= '0;
      pin_q <= '0;
    end
    else
    begin
      sync_a <= raw;
      sync_b <= sync_a;
      sync_c <= sync_b;
      pin_q <= (sync_b & sync_c) | (pin_q & (sync_b ^ sync_c));
    end
  end
  assign {ext_q, mod_q, vlo_q, fault_q, xt_q, rc_q, dco_q} = pin_q;

  // crystal fail-safe
  // consumers of the crystal fall back to the rc oscillator on fault
  assign xt_eff = fault_q ? rc_q : xt_q;
  assign aux_any = rc_q | xt_eff;

  ////////////////////////////////////////////////////////////////////
  // axi write channels: address and data taken in either order
  assign wr_go = !O_AWREADY && !O_WREADY && !O_BVALID;
  assign wr_hit = ({aw_addr[7:2], 2'b00} == csd_pkg::OFS_CLK_CTRL) ||
                  ({aw_addr[7:2], 2'b00} == csd_pkg::OFS_PERIPH_SEL) ||
                  ({aw_addr[7:2], 2'b00} == csd_pkg::OFS_SYS_CONFIG_TWO) ||
                  ({aw_addr[7:2], 2'b00} == csd_pkg::OFS_STATUS);
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      O_AWREADY <= 1'b1;
      O_WREADY <= 1'b1;
      O_BVALID <= 1'b0;
      O_BRESP <= csd_pkg::RESP_OKAY;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end
    else
    begin
      if (I_AWVALID && O_AWREADY)
      begin
        aw_addr <= I_AWADDR;
        O_AWREADY <= 1'b0;
      end
      if (I_WVALID && O_WREADY)
      begin
        w_data <= I_WDATA;
        w_strb <= I_WSTRB;
        O_WREADY <= 1'b0;
      end
      if (wr_go)
      begin
        O_BVALID <= 1'b1;
        O_BRESP <= wr_hit ? csd_pkg::RESP_OKAY : csd_pkg::RESP_SLVERR;
      end
      if (O_BVALID && I_BREADY)
      begin
        O_BVALID <= 1'b0;
        O_AWREADY <= 1'b1;
        O_WREADY <= 1'b1;
      end
    end
  end

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        res[8*b +: 8] = dat[8*b +: 8];
    return res & mask;
  endfunction : merge

  // control registers written by software
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      ctrl <= csd_pkg::CTRL_RST;
      psel <= csd_pkg::PSEL_RST;
      cfg2 <= csd_pkg::CFG2_RST;
    end
    else if (wr_go)
    begin
      if ({aw_addr[7:2], 2'b00} == csd_pkg::OFS_CLK_CTRL)
        ctrl <= merge(ctrl, w_data, w_strb, csd_pkg::CTRL_MASK);
      if ({aw_addr[7:2], 2'b00} == csd_pkg::OFS_PERIPH_SEL)
        psel <= merge(psel, w_data, w_strb, csd_pkg::PSEL_MASK);
      if ({aw_addr[7:2], 2'b00} == csd_pkg::OFS_SYS_CONFIG_TWO)
        cfg2 <= merge(cfg2, w_data, w_strb, csd_pkg::CFG2_MASK);
    end
  end

  // sticky fault flag
  // a fault in the clearing cycle wins, so no event is lost
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      fault_sticky <= 1'b0;
    else if (fault_q)
      fault_sticky <= 1'b1;
    else if (wr_go && ({aw_addr[7:2], 2'b00} == csd_pkg::OFS_STATUS) && w_strb[0] &&
             w_data[csd_pkg::STAT_FAULT])
      fault_sticky <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // axi read channel: one cycle from address to data
  always_comb
  begin
    rd_hit = 1'b1;
    rd_val = '0;
    case ({I_ARADDR[7:2], 2'b00})
      csd_pkg::OFS_CLK_CTRL: rd_val = ctrl;
      csd_pkg::OFS_PERIPH_SEL: rd_val = psel;
      csd_pkg::OFS_SYS_CONFIG_TWO: rd_val = cfg2;
      csd_pkg::OFS_STATUS:
      begin
        rd_val[csd_pkg::STAT_FAULT] = fault_sticky;
        rd_val[csd_pkg::STAT_LIVE] = fault_q;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      O_ARREADY <= 1'b1;
      O_RVALID <= 1'b0;
      O_RDATA <= '0;
      O_RRESP <= csd_pkg::RESP_OKAY;
    end
    else if (I_ARVALID && O_ARREADY)
    begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b1;
      O_RDATA <= rd_val;
      O_RRESP <= rd_hit ? csd_pkg::RESP_OKAY : csd_pkg::RESP_SLVERR;
    end
    else if (O_RVALID && I_RREADY)
    begin
      O_RVALID <= 1'b0;
      O_ARREADY <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // main source set
  // single main clock
  // the modulation clock has no code here, so it can never reach main
  csd_divider #(.W(7), .DW(3)) u_main (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_srcs({vlo_q, xt_eff, rc_q, dco_q}),
    .i_sel(ctrl[csd_pkg::MSRC_LSB +: 2]),
    .i_div(ctrl[csd_pkg::MDIV_LSB +: 3]),
    .o_clk(O_MAIN_CLK)
  );

  csd_divider #(.W(3), .DW(2)) u_sub (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_srcs({4{O_MAIN_CLK}}),
    .i_sel(2'b00),
    .i_div(ctrl[csd_pkg::SDIV_LSB +: 2]),
    .o_clk(O_SUB_MAIN_CLK)
  );

  csd_divider #(.W(1), .DW(1)) u_aux (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_srcs({2'b00, rc_q, xt_eff}),
    .i_sel({1'b0, ctrl[csd_pkg::ASRC_BIT]}),
    .i_div(1'b0),
    .o_clk(O_AUX_CLK)
  );

  csd_divider #(.W(1), .DW(1)) u_fref (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_srcs({2'b00, xt_eff, rc_q}),
    .i_sel({1'b0, ctrl[csd_pkg::FREF_BIT]}),
    .i_div(1'b0),
    .o_clk(O_FLL_REF_CLK)
  );

  ////////////////////////////////////////////////////////////////////
  // counter gate
  // gate follows its bit only while sub-main is low, so no runt pulse
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      gate_act <= 1'b0;
    else if (!O_SUB_MAIN_CLK)
      gate_act <= cfg2[csd_pkg::CTR_GATE_BIT];
  end

  // candidate table, index is the select code
  always_comb
  begin
    cand[csd_pkg::P_TIMER_ZERO] = {vlo_q, O_SUB_MAIN_CLK, O_AUX_CLK, ext_q[0]};
    cand[csd_pkg::P_TIMER_ONE] = {1'b0, O_SUB_MAIN_CLK, O_AUX_CLK, ext_q[1]};
    cand[csd_pkg::P_SERIAL_A] = {O_SUB_MAIN_CLK, O_SUB_MAIN_CLK, O_AUX_CLK, ext_q[2]};
    cand[csd_pkg::P_SERIAL_B] = {O_SUB_MAIN_CLK, O_SUB_MAIN_CLK, O_AUX_CLK, ext_q[3]};
    cand[csd_pkg::P_WATCHDOG] = {1'b0, vlo_q, O_AUX_CLK, O_SUB_MAIN_CLK};
    cand[csd_pkg::P_CONVERTER] = {O_SUB_MAIN_CLK, O_SUB_MAIN_CLK, O_AUX_CLK, mod_q};
    cand[csd_pkg::P_COUNTER] = {vlo_q, xt_eff, O_SUB_MAIN_CLK & gate_act, 1'b0};
  end

  // peripheral switch
  // a new code is taken only while old output, old source and new source are low;
  // checking the old source too stops a one-cycle runt at the switch edge
  for (genvar p = 0; p < csd_pkg::NUM_PERIPH; p++)
  begin : g_periph
    assign swp[p] = (psel[2*p +: 2] != sel_act[p]) && !pclk[p] && !cand[p][sel_act[p]] &&
                    !cand[p][psel[2*p +: 2]];
    always_ff @(posedge I_CLK or posedge I_SYS_RST)
    begin
      if (I_SYS_RST)
      begin
        sel_act[p] <= 2'b00;
        pclk[p] <= 1'b0;
      end
      else
      begin
        if (swp[p])
          sel_act[p] <= psel[2*p +: 2];
        pclk[p] <= cand[p][sel_act[p]];
      end
    end
  end

  // peripheral clock outputs, each a flop bit
  assign {O_COUNTER_CLK, O_CONVERTER_CLK, O_WATCHDOG_CLK, O_SERIAL_B_CLK,
          O_SERIAL_A_CLK, O_TIMER_ONE_CLK, O_TIMER_ZERO_CLK} = pclk;

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SYS_RST);

  sub_slower_a: assert property ($rose(O_SUB_MAIN_CLK) |-> $past(O_MAIN_CLK) || $past(O_MAIN_CLK, 2))
    else $error("sub-main rose without main clock high");
  aux_source_a: assert property ($rose(O_AUX_CLK) |-> $past(aux_any))
    else $error("aux clock rose with no source high");
  fault_flag_a: assert property (fault_q |=> fault_sticky)
    else $error("crystal fault not recorded");
  timer_sub_a: assert property (sel_act[0] == csd_pkg::SEL_SUB |=> O_TIMER_ZERO_CLK == $past(O_SUB_MAIN_CLK))
    else $error("timer zero not on sub-main");
  timer_vlo_a: assert property (sel_act[0] == csd_pkg::SEL_ALT |=> O_TIMER_ZERO_CLK == $past(vlo_q))
    else $error("timer zero not on very low clock");
  serial_alt_a: assert property (sel_act[2] == csd_pkg::SEL_ALT |=> O_SERIAL_A_CLK == $past(O_SUB_MAIN_CLK))
    else $error("serial a code 11 not sub-main");
  watchdog_vlo_a: assert property (sel_act[4] == csd_pkg::WDT_VLO |=> O_WATCHDOG_CLK == $past(vlo_q))
    else $error("watchdog not on very low clock");
  conv_mod_a: assert property (sel_act[5] == csd_pkg::ADC_MOD |=> O_CONVERTER_CLK == $past(mod_q))
    else $error("converter not on modulation clock");
  counter_xtal_a: assert property (sel_act[6] == csd_pkg::RTC_XTAL |=> O_COUNTER_CLK == $past(xt_eff))
    else $error("counter not on crystal clock");
  counter_gate_a: assert property (sel_act[6] == csd_pkg::RTC_SUB && !gate_act |=> !O_COUNTER_CLK)
    else $error("counter clock passed while gated");
  periph_runt_a: assert property (swp[1] |=> !O_TIMER_ONE_CLK)
    else $error("timer one switched while high");
endmodule : csd_clock_select

// ==== bench/csd_osc_model.sv ====
// Purpose: free-running oscillator and clock pin sources for the clock select block
// Assumes: every source is a whole number of I_CLK cycles per half period, at least 3
// Notes: bit order dco, rc, crystal, vlo, modulation, then four external clock pins
`timescale 1ns/1ps

module csd_osc_model #(
  parameter int H [9] = '{4, 6, 10, 14, 5, 7, 9, 11, 13}
) (
  // clock
  input wire logic i_clk,
  // source levels
  output logic [8:0] o_src
);
  int cnt [9];

  ////////////////////////////////////////////////////////////////////
  // levels change only at I_CLK edges so every period is exact in cycles
  initial
  begin
    o_src = 9'h000;
    cnt = '{default: 0};
  end

  // each source toggles after its own half period
  always @(posedge i_clk)
  begin
    for (int k = 0; k < 9; k++)
    begin
      if (cnt[k] == H[k] - 1)
      begin
        cnt[k] <= 0;
        o_src[k] <= ~o_src[k];
      end
      else
        cnt[k] <= cnt[k] + 1;
    end
  end
endmodule : csd_osc_model

// ==== bench/test_clock_select_distribution.sv ====
// Purpose: self-checking bench for clock selection and distribution
// Assumes: output periods are measured in I_CLK cycles after settling
// Notes: a reserved or gated selection is expected to give period 0
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin fails++; $display("wrong value %s expected %0h seen %0h", nm, ex, gt); end end

module test_clock_select_distribution;
  localparam int H [9] = '{4, 6, 10, 14, 5, 7, 9, 11, 13};
  logic I_CLK = 0, I_SYS_RST = 1, I_AWVALID = 0, I_WVALID = 0, I_BREADY = 0, I_ARVALID = 0, I_RREADY = 0;
  logic I_CRYSTAL_FAULT = 0;
  logic [7:0] I_AWADDR = 8'h00, I_ARADDR = 8'h00;
  logic [31:0] I_WDATA = 32'h0;
  logic [3:0] I_WSTRB = 4'h0;
  logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
  logic [1:0] O_BRESP, O_RRESP;
  logic [31:0] O_RDATA, ctrl, psel, rd, rnd;
  logic [8:0] src;
  logic [10:0] outs;
  logic [1:0] rsp;
  logic gate, fault;
  int fails = 0, n_compared = 0;

  ////////////////////////////////////////////////////////////////////
  // clock and partner sources
  always #12.5 I_CLK = ~I_CLK;
  csd_osc_model #(.H(H)) osc (.i_clk(I_CLK), .o_src(src));
  csd_clock_select DUT (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY),
    .I_AWADDR(I_AWADDR), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .I_WDATA(I_WDATA), .I_WSTRB(I_WSTRB),
    .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .O_BRESP(O_BRESP), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
    .I_ARADDR(I_ARADDR), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP),
    .I_DIGITALLY_CONTROLLED_OSC(src[0]), .I_INTERNAL_RC_OSC(src[1]), .I_CRYSTAL_CLOCK(src[2]),
    .I_CRYSTAL_FAULT(I_CRYSTAL_FAULT), .I_VERY_LOW_FREQ_CLOCK(src[3]), .I_MODULATION_CLOCK(src[4]),
    .I_TIMER_ZERO_EXT_CLOCK_PIN(src[5]), .I_TIMER_ONE_EXT_CLOCK_PIN(src[6]), .I_SERIAL_A_EXT_CLOCK_PIN(src[7]),
    .I_SERIAL_B_EXT_CLOCK_PIN(src[8]), .O_MAIN_CLK(outs[0]), .O_SUB_MAIN_CLK(outs[1]), .O_AUX_CLK(outs[2]),
    .O_FLL_REF_CLK(outs[3]), .O_TIMER_ZERO_CLK(outs[4]), .O_TIMER_ONE_CLK(outs[5]), .O_SERIAL_A_CLK(outs[6]),
    .O_SERIAL_B_CLK(outs[7]), .O_WATCHDOG_CLK(outs[8]), .O_CONVERTER_CLK(outs[9]), .O_COUNTER_CLK(outs[10]));

  ////////////////////////////////////////////////////////////////////
  // verdict and run end
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  // pseudo-random source, seeded at 42
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  // axi4-lite write; address and data offered together, each dropped once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int n;
    logic aw_done, w_done;
    @(posedge I_CLK);
    aw_done = 0;
    w_done = 0;
    I_AWADDR <= a;
    I_WDATA <= d;
    I_WSTRB <= s;
    I_AWVALID <= 1;
    I_WVALID <= 1;
    I_BREADY <= 1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge I_CLK);
      if (O_BVALID === 1'b1 && aw_done && w_done)
        break;
      if (I_AWVALID && O_AWREADY === 1'b1)
      begin
        I_AWVALID <= 0;
        aw_done = 1;
      end
      if (I_WVALID && O_WREADY === 1'b1)
      begin
        I_WVALID <= 0;
        w_done = 1;
      end
    end
    r = O_BRESP;
    I_BREADY <= 0;
    if (n == 100)
    begin
      fails++;
      complete_run();
    end
  endtask : axi_write

  // axi4-lite read; rready held until the answer is sampled
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic a_done;
    @(posedge I_CLK);
    a_done = 0;
    I_ARADDR <= a;
    I_ARVALID <= 1;
    I_RREADY <= 1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge I_CLK);
      if (O_RVALID === 1'b1 && a_done)
        break;
      if (I_ARVALID && O_ARREADY === 1'b1)
      begin
        I_ARVALID <= 0;
        a_done = 1;
      end
    end
    d = O_RDATA;
    r = O_RRESP;
    I_RREADY <= 0;
    if (n == 100)
    begin
      fails++;
      complete_run();
    end
  endtask : axi_read

  ////////////////////////////////////////////////////////////////////
  // reference model: expected output period in cycles, 0 for a silent output
  function automatic int exp_per(int i);
    int xt, mn, sb, ax, c;
    xt = fault ? 2 * H[1] : 2 * H[2];
    mn = (ctrl[5:4] == 2'h2 ? xt : 2 * H[ctrl[5:4]]) << ctrl[2:0];
    sb = mn << ctrl[13:12];
    ax = ctrl[8] ? 2 * H[1] : xt;
    c = (i >= 4) ? psel[2 * (i - 4) +: 2] : 0;
    case (i)
      0: return mn;
      1: return sb;
      2: return ax;
      3: return ctrl[16] ? xt : 2 * H[1];
      4: return c == 0 ? 2 * H[5] : c == 1 ? ax : c == 2 ? sb : 2 * H[3];
      5: return c == 0 ? 2 * H[6] : c == 1 ? ax : c == 2 ? sb : 0;
      6, 7: return c == 0 ? 2 * H[i + 1] : c == 1 ? ax : sb;
      8: return c == 0 ? sb : c == 1 ? ax : c == 2 ? 2 * H[3] : 0;
      9: return c == 0 ? 2 * H[4] : c == 1 ? ax : sb;
      default: return c == 0 ? 0 : c == 1 ? (gate ? sb : 0) : c == 2 ? xt : 2 * H[3];
    endcase
  endfunction : exp_per

  // settle long enough for a glitch-free switch, then time two rises per output
  task automatic measure(output int per [11]);
    int first [11];
    int lim;
    logic [10:0] prev;
    lim = 40;
    for (int i = 0; i < 11; i++)
      if (3 * exp_per(i) + 40 > lim)
        lim = 3 * exp_per(i) + 40;
    repeat (lim) @(posedge I_CLK);
    prev = outs;
    per = '{default: 0};
    first = '{default: -1};
    for (int t = 0; t < lim; t++)
    begin
      @(posedge I_CLK);
      for (int i = 0; i < 11; i++)
        if (outs[i] === 1'b1 && prev[i] === 1'b0)
        begin
          if (first[i] < 0)
            first[i] = t;
          else if (per[i] == 0)
            per[i] = t - first[i];
        end
      prev = outs;
    end
  endtask : measure

  // program one configuration and compare every output with the model
  task automatic apply(input logic [31:0] c, input logic [31:0] p, input logic [31:0] g);
    int per [11];
    int old_lim;
    // the old setting may hold a slow level high before it lets go, so wait it out too
    old_lim = 0;
    for (int i = 0; i < 11; i++)
      if (3 * exp_per(i) + 40 > old_lim)
        old_lim = 3 * exp_per(i) + 40;
    ctrl = c & csd_pkg::CTRL_MASK;
    psel = p & csd_pkg::PSEL_MASK;
    gate = g[0];
    axi_write(csd_pkg::OFS_CLK_CTRL, c, 4'hf, rsp);
    axi_write(csd_pkg::OFS_PERIPH_SEL, p, 4'hf, rsp);
    axi_write(csd_pkg::OFS_SYS_CONFIG_TWO, g, 4'hf, rsp);
    repeat (old_lim) @(posedge I_CLK);
    measure(per);
    for (int i = 0; i < 11; i++)
      `CHK("period", exp_per(i), per[i])
    `CHK("outputs known", 1'b0, $isunknown(outs))
  endtask : apply

  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    fault = 0;
    ctrl = 32'h0;
    psel = 32'h0;
    gate = 0;
    rnd = 32'h0000_002a;
    repeat (5) @(posedge I_CLK);
    I_SYS_RST <= 0;
    // reset values and an unmapped read
    for (int a = 0; a < 4; a++)
    begin
      axi_read(8'(4 * a), rd, rsp);
      `CHK("reset value", 32'h0, rd)
    end
    axi_read(8'h10, rd, rsp);
    `CHK("unmapped read", csd_pkg::RESP_SLVERR, rsp)
    axi_write(8'h10, 32'hffff_ffff, 4'hf, rsp);
    `CHK("unmapped write", csd_pkg::RESP_SLVERR, rsp)
    // unimplemented bits read zero, byte lanes merge
    axi_write(csd_pkg::OFS_CLK_CTRL, 32'hffff_ffff, 4'hf, rsp);
    axi_write(csd_pkg::OFS_CLK_CTRL, 32'h0, 4'h2, rsp);
    axi_read(csd_pkg::OFS_CLK_CTRL, rd, rsp);
    `CHK("ctrl merge", csd_pkg::CTRL_MASK & 32'hffff_00ff, rd)
    for (int c = 0; c < 4; c++)
      apply((c << 16) | (c[0] << 8) | (c << 12) | (c << 4) | c, {7{2'(c)}}, c[0]);
    apply(32'h0000_0007, 32'h0000_1111, 32'h1);
    // random settings, main divider kept small to bound the run
    for (int k = 0; k < 4; k++)
    begin
      rnd = lfsr_next(rnd);
      apply(rnd & 32'h0001_3133, lfsr_next(rnd), rnd[20]);
    end
    fault = 1;
    I_CRYSTAL_FAULT <= 1;
    apply(32'h0001_0020, 32'h0000_2000, 32'h0);
    axi_read(csd_pkg::OFS_STATUS, rd, rsp);
    `CHK("fault status", 32'h3, rd)
    fault = 0;
    I_CRYSTAL_FAULT <= 0;
    repeat (8) @(posedge I_CLK);
    axi_read(csd_pkg::OFS_STATUS, rd, rsp);
    `CHK("sticky fault", 32'h1, rd)
    axi_write(csd_pkg::OFS_STATUS, 32'h1, 4'hf, rsp);
    axi_read(csd_pkg::OFS_STATUS, rd, rsp);
    `CHK("fault cleared", 32'h0, rd)
    // mid-run reset clears the selects, then the counter sub-main path is gated off
    I_SYS_RST <= 1;
    repeat (2) @(posedge I_CLK);
    I_SYS_RST <= 0;
    axi_read(csd_pkg::OFS_PERIPH_SEL, rd, rsp);
    `CHK("select after reset", 32'h0, rd)
    apply(32'h0001_0020, 32'h0000_1000, 32'h0);
    complete_run();
  end
endmodule : test_clock_select_distribution
